// [logic/uart_char_buffers_pkg.sv]
package uart_char_buffers_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] rx_buffer_off = 8'h00;
	localparam logic [7:0] tx_holding_off = 8'h04;
	localparam logic [7:0] scratch_off = 8'h08;
	localparam logic [7:0] control_off = 8'h0c;
	localparam logic [7:0] divisor_off = 8'h10;
	localparam logic [7:0] status_off = 8'h14;
	localparam logic [7:0] trigger_off = 8'h18;
	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int ctl_rie_bit = 0;
	localparam int ctl_tie_bit = 1;
	localparam int ctl_fifo_bit = 2;
	localparam int ctl_wlen_lsb = 3;
	localparam int ctl_stop2_bit = 5;
	localparam int ctl_par_en_bit = 6;
	localparam int ctl_par_even_bit = 7;
	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int st_rx_valid_bit = 0;
	localparam int st_hold_empty_bit = 1;
	localparam int st_tx_idle_bit = 2;
	localparam int st_rx_irq_bit = 3;
	localparam int st_tx_irq_bit = 4;
	localparam int st_error_bit = 5;
	localparam int st_count_lsb = 8;
	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [7:0] scratch_reset = 8'h00;
	localparam logic [15:0] divisor_reset = 16'h0001;
	localparam logic [4:0] trigger_reset = 5'h01;
	localparam logic [3:0] mid_tick = 4'h7;
	localparam logic [3:0] last_tick = 4'hf;
	localparam int char_fifo_depth = 16;
	localparam int skid_depth = 2;
	typedef enum logic [2:0] {st_idle, st_start, st_data, st_parity, st_stop} line_state_t;
endpackage

// [logic/uart_char_buffers.sv]
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module char_fifo #(
	parameter int width = 8,
	parameter int depth = 16,
	parameter int aw = $clog2(depth)
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic single_in,
	input wire logic in_valid_in,
	input wire logic [width-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [width-1:0] out_data_out,
	input wire logic out_ready_in,
	output logic [aw:0] count_out
);
	// Depth must be a power of two: pointers wrap by overflow
	localparam logic [aw:0] full_count = (aw+1)'(depth);
	logic [width-1:0] mem_q [depth];
	logic [aw-1:0] wr_q;
	logic [aw-1:0] rd_q;
	logic [aw:0] count_q;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;
	assign in_ready_out = single_in ? (count_q == '0) : (count_q != full_count);
	assign out_valid_out = (count_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign count_out = count_q;
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

module uart_char_buffers (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic serial_rx_in,
	output logic serial_tx_out,
	output logic rx_irq_out,
	output logic tx_irq_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic pready_q, pslverr_q, rd_pop_q, stat_rd_q;
	logic [31:0] prdata_q;
	logic [7:0] scratch_q, control_q;
	logic [15:0] divisor_q, div_cnt_q;
	logic [4:0] trigger_q;
	logic tick_q, rx_irq_q, tx_irq_q, line_error_q;
	logic rx_meta_q, rx_sync_q;
	uart_char_buffers_pkg::line_state_t rx_state_q, tx_state_q;
	logic [3:0] rx_sub_q, tx_sub_q;
	logic [2:0] rx_bit_q, tx_bit_q;
	logic [7:0] rx_shift_q, rx_char_q, tx_shift_q;
	logic rx_push_q, rx_bad_q, tx_q, tx_par_q, tx_stop2_q;
	logic rx_in_ready, rx_valid, tx_in_ready, tx_valid, buf_in_ready, buf_valid;
	logic [7:0] rx_head, tx_head, buf_head;
	logic [4:0] rx_count, tx_count;
	logic [1:0] buf_count;

	function automatic logic parity_of(input logic [7:0] data, input logic [1:0] wlen, input logic even);
		logic [7:0] mask;
		mask = 8'hff >> (2'd3 - wlen);
		return (^(data & mask)) ^ ~even;
	endfunction

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire apb_access = psel_in & penable_in;
	wire apb_capture = apb_access & ~pready_q;
	wire apb_done = apb_access & pready_q;
	wire apb_wr = apb_done & pwrite_in;
	wire hit_rx = (paddr_in == uart_char_buffers_pkg::rx_buffer_off);
	wire hit_tx = (paddr_in == uart_char_buffers_pkg::tx_holding_off);
	wire hit_scratch = (paddr_in == uart_char_buffers_pkg::scratch_off);
	wire hit_control = (paddr_in == uart_char_buffers_pkg::control_off);
	wire hit_divisor = (paddr_in == uart_char_buffers_pkg::divisor_off);
	wire hit_status = (paddr_in == uart_char_buffers_pkg::status_off);
	wire hit_trigger = (paddr_in == uart_char_buffers_pkg::trigger_off);
	wire mapped = hit_rx | hit_tx | hit_scratch | hit_control | hit_divisor | hit_status | hit_trigger;

	wire rie = control_q[uart_char_buffers_pkg::ctl_rie_bit];
	wire tie = control_q[uart_char_buffers_pkg::ctl_tie_bit];
	wire fifo_mode = control_q[uart_char_buffers_pkg::ctl_fifo_bit];
	wire [1:0] wlen = control_q[uart_char_buffers_pkg::ctl_wlen_lsb +: 2];
	wire stop2 = control_q[uart_char_buffers_pkg::ctl_stop2_bit];
	wire par_en = control_q[uart_char_buffers_pkg::ctl_par_en_bit];
	wire par_even = control_q[uart_char_buffers_pkg::ctl_par_even_bit];
	wire [2:0] last_bit = 3'd4 + {1'b0, wlen};
	wire holding_empty = (tx_count == '0) & (buf_count == '0);
	wire tx_idle = (tx_state_q == uart_char_buffers_pkg::st_idle);

	wire [31:0] status_word = {19'h0, rx_count, 2'h0, line_error_q, tx_irq_q, rx_irq_q, tx_idle, holding_empty,
		rx_valid};
	wire [31:0] read_word = hit_rx ? {24'h0, rx_valid ? rx_head : 8'h00} :
		hit_scratch ? {24'h0, scratch_q} :
		hit_control ? {24'h0, control_q} :
		hit_divisor ? {16'h0, divisor_q} :
		hit_status ? status_word :
		hit_trigger ? {27'h0, trigger_q} : 32'h0;

	// Pop only a character whose value was captured for this very read
	wire rx_pop = apb_done & ~pwrite_in & rd_pop_q;
	wire tx_push = apb_wr & hit_tx;
	wire stat_clear = apb_done & ~pwrite_in & stat_rd_q;
	wire err_set = rx_push_q & (rx_bad_q | ~rx_in_ready);

	// ----------------------------------------------------------------
	// Bus slave and registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
			rd_pop_q <= 1'b0;
			stat_rd_q <= 1'b0;
		end else begin
			pready_q <= apb_capture;
			if (apb_capture) begin
				pslverr_q <= ~mapped;
				prdata_q <= pwrite_in ? 32'h0 : read_word;
				rd_pop_q <= hit_rx & rx_valid;
				stat_rd_q <= hit_status;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			scratch_q <= uart_char_buffers_pkg::scratch_reset;
			control_q <= uart_char_buffers_pkg::control_reset;
			divisor_q <= uart_char_buffers_pkg::divisor_reset;
			trigger_q <= uart_char_buffers_pkg::trigger_reset;
		end else if (apb_wr) begin
			if (hit_scratch) begin
				scratch_q <= pwdata_in[7:0];
			end
			if (hit_control) begin
				control_q <= pwdata_in[7:0];
			end
			if (hit_divisor) begin
				divisor_q <= pwdata_in[15:0];
			end
			if (hit_trigger) begin
				trigger_q <= pwdata_in[4:0];
			end
		end
	end

	// Set wins over the clear by status read
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			line_error_q <= 1'b0;
		end else begin
			line_error_q <= err_set | (line_error_q & ~stat_clear);
		end
	end

	// ----------------------------------------------------------------
	// Interrupt levels
	// ----------------------------------------------------------------
	wire rx_irq_d = rie & (fifo_mode ? (rx_count >= trigger_q) : (rx_count != '0));
	wire tx_irq_d = tie & holding_empty;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rx_irq_q <= 1'b0;
			tx_irq_q <= 1'b0;
		end else begin
			rx_irq_q <= rx_irq_d;
			tx_irq_q <= tx_irq_d;
		end
	end

	// ----------------------------------------------------------------
	// Baud divider, one enable per sixteenth of a bit
	// ----------------------------------------------------------------
	wire [15:0] div_load = (divisor_q == 16'h0) ? 16'h0 : divisor_q - 16'h1;
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			div_cnt_q <= 16'h0;
			tick_q <= 1'b0;
		end else if (apb_wr && hit_divisor) begin
			div_cnt_q <= pwdata_in[15:0]; // Reload so a new divisor never waits out an old long count
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_cnt_q == 16'h0);
			div_cnt_q <= (div_cnt_q == 16'h0) ? div_load : div_cnt_q - 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
		end else begin
			rx_meta_q <= serial_rx_in;
			rx_sync_q <= rx_meta_q;
		end
	end

	wire [7:0] rx_aligned = rx_shift_q >> (2'd3 - wlen);
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rx_state_q <= uart_char_buffers_pkg::st_idle;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_shift_q <= 8'h00;
			rx_char_q <= 8'h00;
			rx_push_q <= 1'b0;
			rx_bad_q <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			if (tick_q) begin
				rx_sub_q <= rx_sub_q + 4'h1;
				case (rx_state_q)
					uart_char_buffers_pkg::st_idle: begin
						rx_sub_q <= 4'h0;
						rx_bad_q <= 1'b0;
						if (!rx_sync_q) begin
							rx_state_q <= uart_char_buffers_pkg::st_start;
						end
					end
					uart_char_buffers_pkg::st_start: begin
						if (rx_sub_q == uart_char_buffers_pkg::mid_tick) begin
							rx_sub_q <= 4'h0;
							rx_bit_q <= 3'h0;
							// A start bit gone high by mid-bit was a glitch
							rx_state_q <= rx_sync_q ? uart_char_buffers_pkg::st_idle : uart_char_buffers_pkg::st_data;
						end
					end
					uart_char_buffers_pkg::st_data: begin
						if (rx_sub_q == uart_char_buffers_pkg::last_tick) begin
							rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
							rx_bit_q <= rx_bit_q + 3'h1;
							if (rx_bit_q == last_bit) begin
								rx_state_q <= par_en ? uart_char_buffers_pkg::st_parity : uart_char_buffers_pkg::st_stop;
							end
						end
					end
					uart_char_buffers_pkg::st_parity: begin
						if (rx_sub_q == uart_char_buffers_pkg::last_tick) begin
							rx_bad_q <= (rx_sync_q != parity_of(rx_aligned, wlen, par_even));
							rx_state_q <= uart_char_buffers_pkg::st_stop;
						end
					end
					uart_char_buffers_pkg::st_stop: begin
						if (rx_sub_q == uart_char_buffers_pkg::last_tick) begin
							rx_bad_q <= rx_bad_q | ~rx_sync_q;
							rx_char_q <= rx_aligned;
							rx_push_q <= 1'b1;
							rx_state_q <= uart_char_buffers_pkg::st_idle;
						end
					end
					default: begin
						rx_state_q <= uart_char_buffers_pkg::st_idle;
					end
				endcase
			end
		end
	end

	// Legacy mode holds a single character; a second one overruns
	char_fifo #(.width(8), .depth(uart_char_buffers_pkg::char_fifo_depth)) rx_fifo (
		.clock_in(clock_in), .rst_in(rst_in), .single_in(~fifo_mode),
		.in_valid_in(rx_push_q), .in_data_in(rx_char_q), .in_ready_out(rx_in_ready),
		.out_valid_out(rx_valid), .out_data_out(rx_head), .out_ready_in(rx_pop),
		.count_out(rx_count)
	);

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	char_fifo #(.width(8), .depth(uart_char_buffers_pkg::char_fifo_depth)) tx_fifo (
		.clock_in(clock_in), .rst_in(rst_in), .single_in(~fifo_mode),
		.in_valid_in(tx_push), .in_data_in(pwdata_in[7:0]), .in_ready_out(tx_in_ready),
		.out_valid_out(tx_valid), .out_data_out(tx_head), .out_ready_in(buf_in_ready),
		.count_out(tx_count)
	);

	wire tx_load = tx_idle & buf_valid;
	char_fifo #(.width(8), .depth(uart_char_buffers_pkg::skid_depth)) tx_skid (
		.clock_in(clock_in), .rst_in(rst_in), .single_in(1'b0),
		.in_valid_in(tx_valid), .in_data_in(tx_head), .in_ready_out(buf_in_ready),
		.out_valid_out(buf_valid), .out_data_out(buf_head), .out_ready_in(tx_load),
		.count_out(buf_count)
	);

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			tx_state_q <= uart_char_buffers_pkg::st_idle;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_shift_q <= 8'h00;
			tx_q <= 1'b1;
			tx_par_q <= 1'b0;
			tx_stop2_q <= 1'b0;
		end else if (tx_load) begin
			tx_shift_q <= buf_head;
			tx_par_q <= parity_of(buf_head, wlen, par_even);
			tx_sub_q <= 4'h0;
			tx_q <= 1'b0;
			tx_state_q <= uart_char_buffers_pkg::st_start;
		end else if (tick_q && !tx_idle) begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_sub_q == uart_char_buffers_pkg::last_tick) begin
				case (tx_state_q)
					uart_char_buffers_pkg::st_start: begin
						tx_q <= tx_shift_q[0];
						tx_shift_q <= tx_shift_q >> 1;
						tx_bit_q <= 3'h0;
						tx_state_q <= uart_char_buffers_pkg::st_data;
					end
					uart_char_buffers_pkg::st_data: begin
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_q <= tx_shift_q[0];
						tx_shift_q <= tx_shift_q >> 1;
						if (tx_bit_q == last_bit) begin
							tx_q <= par_en ? tx_par_q : 1'b1;
							tx_stop2_q <= 1'b0;
							tx_state_q <= par_en ? uart_char_buffers_pkg::st_parity : uart_char_buffers_pkg::st_stop;
						end
					end
					uart_char_buffers_pkg::st_parity: begin
						tx_q <= 1'b1;
						tx_state_q <= uart_char_buffers_pkg::st_stop;
					end
					uart_char_buffers_pkg::st_stop: begin
						tx_stop2_q <= 1'b1;
						if (!stop2 || tx_stop2_q) begin
							tx_state_q <= uart_char_buffers_pkg::st_idle;
						end
					end
					default: begin
						tx_q <= 1'b1;
						tx_state_q <= uart_char_buffers_pkg::st_idle;
					end
				endcase
			end
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign serial_tx_out = tx_q;
	assign rx_irq_out = rx_irq_q;
	assign tx_irq_out = tx_irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence s_scratch_write;
		apb_wr && hit_scratch;
	endsequence
	sequence s_last_rx_read;
		!fifo_mode && rx_pop && rx_count == 5'd1 && !rx_push_q;
	endsequence
	a_rx_depth_limit: assert property (rx_count <= 5'd16) else $error("rx fifo overfilled");
	a_rx_char_pushed: assert property (rx_push_q && rx_in_ready && !rx_pop |=> rx_count == $past(rx_count) + 5'd1)
		else $error("received char not stored");
	a_rx_irq_legacy: assert property (!fifo_mode && rie && rx_count != '0 |=> rx_irq_out)
		else $error("legacy rx irq missing");
	a_rx_irq_clear: assert property (s_last_rx_read ##1 !fifo_mode |=> !rx_irq_out)
		else $error("rx irq not cleared by read");
	a_fifo_rx_trigger: assert property (fifo_mode && rie && rx_count < trigger_q |=> !rx_irq_out)
		else $error("fifo rx irq below trigger");
	a_baud_spacing: assert property (tick_q && divisor_q > 16'h1 && !(apb_wr && hit_divisor) |=> !tick_q)
		else $error("baud tick too frequent");
	a_scratch_hold: assert property (s_scratch_write |=> scratch_q == $past(pwdata_in[7:0]))
		else $error("scratchpad write lost");
	a_tx_fifo_accept: assert property (tx_push && tx_in_ready && !buf_in_ready |=> tx_count == $past(tx_count) + 5'd1)
		else $error("tx write not stored");
	a_tx_load_start: assert property (tx_load |=> tx_state_q == uart_char_buffers_pkg::st_start && !serial_tx_out)
		else $error("tx shifter did not load");
	a_tx_irq_legacy: assert property (tie && holding_empty |=> tx_irq_out)
		else $error("tx empty irq missing");
	a_tx_irq_clear: assert property (!fifo_mode && tx_push && tx_in_ready |=> ##1 !tx_irq_out)
		else $error("tx irq not cleared by write");
	a_tx_idle_mark: assert property (tx_idle |-> serial_tx_out) else $error("tx not at mark when idle");
endmodule

// [tb/serial_peer.sv]
`timescale 1ns/100ps
module serial_peer (
	input wire logic clock_in,
	input wire logic line_in,
	output logic line_out
);
	// Clocks per tick; the bench keeps it equal to the programmed divisor
	int div = 1;
	logic [7:0] got[$];
	logic [7:0] rx_c;
	// Bit after the data: the stop bit, or the parity bit when enabled
	logic ninth_bit = 1'b1;
	initial line_out = 1'b1;
	// ----------------------------------------------------------------
	// Frame generator: start, 8 data LSB first, one stop, then mark
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] c);
		@(posedge clock_in);
		line_out <= 1'b0;
		repeat (16 * div) @(posedge clock_in);
		for (int i = 0; i < 8; i++) begin
			line_out <= c[i];
			repeat (16 * div) @(posedge clock_in);
		end
		line_out <= 1'b1;
		repeat (16 * div) @(posedge clock_in);
	endtask
	// ----------------------------------------------------------------
	// Frame receiver, sampled mid-bit on the falling clock edge
	// ----------------------------------------------------------------
	always begin
		@(negedge line_in);
		repeat (8 * div) @(negedge clock_in);
		// A glitch shorter than half a bit is not a start
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (16 * div) @(negedge clock_in);
				rx_c[i] = line_in;
			end
			repeat (16 * div) @(negedge clock_in);
			ninth_bit = line_in;
			got.push_back(rx_c);
		end
	end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_line;
	logic tx_line;
	logic rx_irq;
	logic tx_irq;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed;
	logic [31:0] r;
	logic e;
	logic [7:0] ch;
	logic [7:0] exp_q[$];

	uart_char_buffers u_dut (.clock_in(clock_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .serial_rx_in(rx_line), .serial_tx_out(tx_line), .rx_irq_out(rx_irq),
		.tx_irq_out(tx_irq));
	serial_peer u_peer (.clock_in(clock_in), .line_in(tx_line), .line_out(rx_line));

	initial forever #2.5 clock_in = ~clock_in;

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Whole run is near 7500 cycles; the ceiling leaves ample margin
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			mismatches++;
			conclude();
		end
	end
	// ----------------------------------------------------------------
	// Bus and line helpers
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		// Read at the edge itself, before the slave's registers move; only the run ceiling ends a hang
		do begin
			@(posedge clock_in);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check_tx();
		int k;
		logic [7:0] y;
		k = 0;
		while (u_peer.got.size() < exp_q.size() && k < 20000) begin
			@(posedge clock_in);
			k++;
		end
		while (exp_q.size() > 0) begin
			ch = exp_q.pop_front();
			y = (u_peer.got.size() > 0) ? u_peer.got.pop_front() : ~ch;
			`CHK("tx char", ch, y)
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h461a;
		repeat (16) @(posedge clock_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			ch = 8'($random(seed));
			apb(1'b1, uart_char_buffers_pkg::scratch_off, {24'h0, ch});
			apb(1'b0, uart_char_buffers_pkg::scratch_off, 32'h0);
			`CHK("scratch", {24'h0, ch}, r)
		end
		apb(1'b0, uart_char_buffers_pkg::control_off, 32'h0);
		`CHK("control", 32'h0, r)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped err", 1'b1, e)
		$display("test scratch done");
		apb(1'b1, uart_char_buffers_pkg::control_off, 32'h1b);
		repeat (2) @(negedge clock_in);
		`CHK("tx irq empty", 1'b1, tx_irq)
		`CHK("line idle", 1'b1, tx_line)
		for (int i = 0; i < 3; i++) begin
			ch = 8'($random(seed));
			exp_q.push_back(ch);
			apb(1'b1, uart_char_buffers_pkg::tx_holding_off, {24'h0, ch});
		end
		@(negedge clock_in);
		`CHK("tx irq loaded", 1'b0, tx_irq)
		check_tx();
		@(negedge clock_in);
		`CHK("tx irq drained", 1'b1, tx_irq)
		`CHK("line rest", 1'b1, tx_line)
		$display("test legacy tx done");
		ch = 8'($random(seed));
		u_peer.send(ch);
		repeat (4) @(negedge clock_in);
		`CHK("rx irq", 1'b1, rx_irq)
		apb(1'b0, uart_char_buffers_pkg::rx_buffer_off, 32'h0);
		`CHK("rx char", {24'h0, ch}, r)
		repeat (2) @(negedge clock_in);
		`CHK("rx irq clear", 1'b0, rx_irq)
		$display("test legacy rx done");
		// Seven-bit frames: the peer sees the stop bit as data bit 7
		apb(1'b1, uart_char_buffers_pkg::divisor_off, 32'h3);
		u_peer.div = 3;
		apb(1'b0, uart_char_buffers_pkg::divisor_off, 32'h0);
		`CHK("divisor", 32'h3, r)
		apb(1'b1, uart_char_buffers_pkg::control_off, 32'h13);
		ch = 8'($random(seed)) | 8'h80;
		exp_q.push_back(ch);
		apb(1'b1, uart_char_buffers_pkg::tx_holding_off, {24'h0, ch});
		check_tx();
		u_peer.send(ch);
		repeat (4) @(negedge clock_in);
		apb(1'b0, uart_char_buffers_pkg::rx_buffer_off, 32'h0);
		`CHK("rx 7 bit", {25'h0, ch[6:0]}, r)
		apb(1'b1, uart_char_buffers_pkg::divisor_off, 32'h1);
		u_peer.div = 1;
		// Even parity, two stops; the peer's own stop bit lands where parity is expected
		apb(1'b1, uart_char_buffers_pkg::control_off, 32'hfb);
		ch = 8'($random(seed));
		exp_q.push_back(ch);
		apb(1'b1, uart_char_buffers_pkg::tx_holding_off, {24'h0, ch});
		check_tx();
		`CHK("tx parity", ^ch, u_peer.ninth_bit)
		u_peer.send(ch);
		repeat (24) @(negedge clock_in);
		apb(1'b0, uart_char_buffers_pkg::status_off, 32'h0);
		`CHK("parity error", ~^ch, r[uart_char_buffers_pkg::st_error_bit])
		apb(1'b0, uart_char_buffers_pkg::status_off, 32'h0);
		`CHK("error cleared", 1'b0, r[uart_char_buffers_pkg::st_error_bit])
		apb(1'b0, uart_char_buffers_pkg::rx_buffer_off, 32'h0);
		`CHK("rx parity char", {24'h0, ch}, r)
		$display("test format done");
		apb(1'b1, uart_char_buffers_pkg::control_off, 32'h1d);
		apb(1'b1, uart_char_buffers_pkg::trigger_off, 32'h10);
		for (int i = 0; i < 16; i++) begin
			ch = 8'($random(seed));
			exp_q.push_back(ch);
			u_peer.send(ch);
			@(negedge clock_in);
			if (i == 14)
				`CHK("rx below trigger", 1'b0, rx_irq)
		end
		repeat (4) @(negedge clock_in);
		`CHK("rx at trigger", 1'b1, rx_irq)
		while (exp_q.size() > 0) begin
			ch = exp_q.pop_front();
			apb(1'b0, uart_char_buffers_pkg::rx_buffer_off, 32'h0);
			`CHK("rx fifo", {24'h0, ch}, r)
		end
		$display("test rx fifo done");
		for (int i = 0; i < 16; i++) begin
			ch = 8'($random(seed));
			exp_q.push_back(ch);
			apb(1'b1, uart_char_buffers_pkg::tx_holding_off, {24'h0, ch});
		end
		check_tx();
		$display("test tx fifo done");
		conclude();
	end
endmodule
